// ==== hw/sqs_pkg.sv ====
package sqs_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_RAIL_B = 8'h10;
  localparam logic [7:0] IDX_RAIL_A = 8'h11;
  localparam logic [7:0] IDX_RST    = 8'h12;
  localparam logic [7:0] IDX_GPIN   = 8'h13;
  localparam logic [7:0] IDX_DUR    = 8'h20;
  localparam logic [7:0] IDX_CTRL   = 8'h21;
  localparam logic [7:0] IDX_STAT   = 8'h22;
  // Slot register fields
  localparam int POL_BIT = 7;
  localparam int UP_LSB  = 4;
  localparam int DN_LSB  = 0;
  localparam int RSV_BIT = 3;
  // Control register fields
  localparam int CTRL_UP_BIT   = 0;
  localparam int CTRL_DN_BIT   = 1;
  localparam int CTRL_GOUT_BIT = 2;
  // Slot plan
  localparam int         SLOT_W    = 3;
  localparam int         DUR_W     = 2;
  localparam int         NUM_SLOTS = 8;
  localparam logic [2:0] LAST_SLOT = 3'h7;
  localparam logic [1:0] DUR_ZERO  = 2'h0;
  localparam logic [1:0] DUR_ONE   = 2'h1;
  localparam logic [1:0] DUR_TWO   = 2'h2;
  // Slot durations in microseconds and clock rate
  localparam int CLK_MHZ = 125;
  localparam int T1_US   = 1500;
  localparam int T2_US   = 3000;
  localparam int T3_US   = 10000;
  localparam int T1_CYC  = T1_US * CLK_MHZ;
  localparam int T2_CYC  = T2_US * CLK_MHZ;
  localparam int T3_CYC  = T3_US * CLK_MHZ;
  localparam int CNT_W   = 21;

  typedef struct packed {
    logic       pol;
    logic [2:0] up;
    logic [2:0] down;
  } sqs_slot_t;

  typedef struct packed {
    sqs_slot_t   rail_b;
    sqs_slot_t   rail_a;
    sqs_slot_t   rst;
    sqs_slot_t   gpin;
    logic [15:0] dur;
  } sqs_nvm_t;

  typedef enum logic [1:0] {SQS_OFF, SQS_UP, SQS_ON, SQS_DOWN} sqs_mode_t;
  typedef enum logic [1:0] {PH_ACT, PH_WAIT, PH_TIME} sqs_phase_t;
endpackage

// ==== hw/sqs_slot_timer.sv ====
`timescale 1ns/10ps
module sqs_slot_timer #(
  parameter int CNT_W = sqs_pkg::CNT_W,
  parameter int C1    = sqs_pkg::T1_CYC,
  parameter int C2    = sqs_pkg::T2_CYC,
  parameter int C3    = sqs_pkg::T3_CYC
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       start,
  input  wire logic [1:0] code,
  output logic            done
);
  typedef struct packed {
    logic             busy;
    logic [CNT_W-1:0] cnt;
  } sqs_tmr_t;

  sqs_tmr_t st;
  sqs_tmr_t next_st;

  // Loads one less than the count so a slot lasts its full cycle count
  always_comb begin
    next_st = st;
    if (st.busy && st.cnt == '0) begin
      next_st.busy = 1'h0;
    end else if (st.busy) begin
      next_st.cnt = st.cnt - 1'h1;
    end
    if (start && !st.busy) begin
      next_st.busy = 1'h1;
      case (code)
        sqs_pkg::DUR_ZERO: next_st.cnt = '0;
        sqs_pkg::DUR_ONE:  next_st.cnt = CNT_W'(C1 - 1);
        sqs_pkg::DUR_TWO:  next_st.cnt = CNT_W'(C2 - 1);
        default:           next_st.cnt = CNT_W'(C3 - 1);
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.busy && st.cnt == '0;
endmodule

// ==== hw/sqs_gpin.sv ====
`timescale 1ns/10ps
module sqs_gpin (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pol,
  input  wire logic is_out,
  input  wire logic seq_on,
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe_n,
  output logic      at_on,
  output logic      at_off
);
  typedef struct packed {
    logic out;
    logic oe_n;
  } sqs_pin_t;

  sqs_pin_t st;
  sqs_pin_t next_st;

  always_comb begin
    next_st.out  = seq_on ^ pol;
    next_st.oe_n = !is_out;
  end

  // Pin starts undriven so nothing is forced before the defaults load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '{out: 1'h0, oe_n: 1'h1};
    end else begin
      st <= next_st;
    end
  end

  assign pin_out  = st.out;
  assign pin_oe_n = st.oe_n;
  assign at_on    = pin_in != pol;
  assign at_off   = pin_in == pol;
endmodule

// ==== hw/sqs_seq.sv ====
// What this block does
// - Rail B slot register bits 6-4 pick its power-up slot, codes 0 to 7.
// - Rail B slot register bits 2-0 pick its power-down slot.
// - Rail A slot register bits 6-4 pick its power-up slot, read/write.
// - Rail A slot register bits 2-0 pick its power-down slot, read/write.
// - Reset-out register bits 6-4 pick the slot releasing the reset pin.
// - Reset-out register bits 2-0 pick the slot asserting the reset pin.
// - Every slot field loads its reset value from non-volatile defaults.
// - General pin bit 7 is polarity: 0 high means on, 1 low means on.
// - Output general pin goes on in its power-up slot.
// - Input general pin holds power-up in its slot until on level seen.
// - Output general pin goes off in its power-down slot.
// - Input general pin holds power-down in its slot until off level seen.
// - Slot duration code: 0 is 0ms, 1 is 1.5ms, 2 is 3ms, 3 is 10ms.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/10ps
module sqs_seq #(
  parameter int DUR1_CYC = sqs_pkg::T1_CYC,
  parameter int DUR2_CYC = sqs_pkg::T2_CYC,
  parameter int DUR3_CYC = sqs_pkg::T3_CYC
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire sqs_pkg::sqs_nvm_t nvm_defaults,
  output logic                   rail_a_en,
  output logic                   rail_b_en,
  output logic                   reset_out_n,
  input  wire logic              gpin_in,
  output logic                   gpin_out,
  output logic                   gpin_oe_n
);
  typedef struct packed {
    logic                loaded;
    sqs_pkg::sqs_slot_t  rb;
    sqs_pkg::sqs_slot_t  ra;
    sqs_pkg::sqs_slot_t  rs;
    sqs_pkg::sqs_slot_t  gp;
    logic [15:0]         dur;
    logic                gout;
    logic                dv;
    logic                dwr;
    logic [7:0]          didx;
    logic [31:0]         rdata;
    sqs_pkg::sqs_mode_t  mode;
    sqs_pkg::sqs_phase_t ph;
    logic [2:0]          slot;
    logic                ra_en;
    logic                rb_en;
    logic                rst_rel;
    logic                gp_on;
  } sqs_state_t;

  sqs_state_t st;
  sqs_state_t next_st;
  logic       seq_up;
  logic       up_wr;
  logic       dn_wr;
  logic       tmr_start;
  logic [1:0] tmr_code;
  logic       tmr_done;
  logic       at_on;
  logic       at_off;
  logic [7:0] aidx;
  logic [2:0] sel_a;
  logic [2:0] sel_b;
  logic [2:0] sel_r;
  logic [2:0] sel_g;

  // Bits 7 and 3 of the rail and reset registers never store
  function automatic sqs_pkg::sqs_slot_t to_slot(input logic [7:0] d, input logic has_pol);
    to_slot.pol  = has_pol & d[sqs_pkg::POL_BIT];
    to_slot.up   = d[sqs_pkg::UP_LSB +: sqs_pkg::SLOT_W];
    to_slot.down = d[sqs_pkg::DN_LSB +: sqs_pkg::SLOT_W];
  endfunction

  function automatic logic [31:0] to_word(input sqs_pkg::sqs_slot_t s);
    to_word = {24'h00_0000, s.pol, s.up, 1'h0, s.down};
  endfunction

  assign seq_up   = st.mode == sqs_pkg::SQS_UP;
  assign aidx     = haddr[9:2];
  assign tmr_code = st.dur[{st.slot, 1'h0} +: sqs_pkg::DUR_W];
  assign sel_a    = seq_up ? st.ra.up : st.ra.down;
  assign sel_b    = seq_up ? st.rb.up : st.rb.down;
  assign sel_r    = seq_up ? st.rs.up : st.rs.down;
  assign sel_g    = seq_up ? st.gp.up : st.gp.down;

  always_comb begin
    next_st   = st;
    up_wr     = 1'h0;
    dn_wr     = 1'h0;
    tmr_start = 1'h0;
    // Defaults are caught on the first edge after reset release
    if (!st.loaded) begin
      next_st.loaded = 1'h1;
      next_st.rb     = nvm_defaults.rail_b;
      next_st.ra     = nvm_defaults.rail_a;
      next_st.rs     = nvm_defaults.rst;
      next_st.gp     = nvm_defaults.gpin;
      next_st.dur    = nvm_defaults.dur;
      // Rails and reset have no polarity; a stray default bit must not read back
      next_st.rb.pol = 1'h0;
      next_st.ra.pol = 1'h0;
      next_st.rs.pol = 1'h0;
    end
    // Data phase of a write
    if (st.dv && st.dwr) begin
      if (st.didx == sqs_pkg::IDX_RAIL_B) begin
        next_st.rb = to_slot(hwdata[7:0], 1'h0);
      end else if (st.didx == sqs_pkg::IDX_RAIL_A) begin
        next_st.ra = to_slot(hwdata[7:0], 1'h0);
      end else if (st.didx == sqs_pkg::IDX_RST) begin
        next_st.rs = to_slot(hwdata[7:0], 1'h0);
      end else if (st.didx == sqs_pkg::IDX_GPIN) begin
        next_st.gp = to_slot(hwdata[7:0], 1'h1);
      end else if (st.didx == sqs_pkg::IDX_DUR) begin
        next_st.dur = hwdata[15:0];
      end else if (st.didx == sqs_pkg::IDX_CTRL) begin
        next_st.gout = hwdata[sqs_pkg::CTRL_GOUT_BIT];
        up_wr        = hwdata[sqs_pkg::CTRL_UP_BIT];
        dn_wr        = hwdata[sqs_pkg::CTRL_DN_BIT];
      end
    end
    // Sequence engine; a request outside its resting mode is dropped
    case (st.mode)
      sqs_pkg::SQS_OFF: begin
        if (up_wr) begin
          next_st.mode = sqs_pkg::SQS_UP;
          next_st.slot = 3'h0;
          next_st.ph   = sqs_pkg::PH_ACT;
        end
      end
      sqs_pkg::SQS_ON: begin
        if (dn_wr) begin
          next_st.mode = sqs_pkg::SQS_DOWN;
          next_st.slot = 3'h0;
          next_st.ph   = sqs_pkg::PH_ACT;
        end
      end
      default: begin
        case (st.ph)
          sqs_pkg::PH_ACT: begin
            if (sel_a == st.slot) begin
              next_st.ra_en = seq_up;
            end
            if (sel_b == st.slot) begin
              next_st.rb_en = seq_up;
            end
            if (sel_r == st.slot) begin
              next_st.rst_rel = seq_up;
            end
            if (st.gout && sel_g == st.slot) begin
              next_st.gp_on = seq_up;
            end
            if (!st.gout && sel_g == st.slot) begin
              next_st.ph = sqs_pkg::PH_WAIT;
            end else begin
              next_st.ph = sqs_pkg::PH_TIME;
              tmr_start  = 1'h1;
            end
          end
          sqs_pkg::PH_WAIT: begin
            if (seq_up ? at_on : at_off) begin
              next_st.ph = sqs_pkg::PH_TIME;
              tmr_start  = 1'h1;
            end
          end
          default: begin
            if (tmr_done) begin
              next_st.ph = sqs_pkg::PH_ACT;
              if (st.slot == sqs_pkg::LAST_SLOT) begin
                next_st.mode = seq_up ? sqs_pkg::SQS_ON : sqs_pkg::SQS_OFF;
              end else begin
                next_st.slot = st.slot + 3'h1;
              end
            end
          end
        endcase
      end
    endcase
    // Address phase; read data built from post-write values so a read
    // right behind a write sees the new contents
    next_st.dv = hsel && hready && htrans[1];
    if (next_st.dv) begin
      next_st.dwr  = hwrite;
      next_st.didx = aidx;
    end
    if (next_st.dv && !hwrite) begin
      if (aidx == sqs_pkg::IDX_RAIL_B) begin
        next_st.rdata = to_word(next_st.rb);
      end else if (aidx == sqs_pkg::IDX_RAIL_A) begin
        next_st.rdata = to_word(next_st.ra);
      end else if (aidx == sqs_pkg::IDX_RST) begin
        next_st.rdata = to_word(next_st.rs);
      end else if (aidx == sqs_pkg::IDX_GPIN) begin
        next_st.rdata = to_word(next_st.gp);
      end else if (aidx == sqs_pkg::IDX_DUR) begin
        next_st.rdata = {16'h0000, next_st.dur};
      end else if (aidx == sqs_pkg::IDX_CTRL) begin
        next_st.rdata = {29'h0000_0000, next_st.gout, 2'h0};
      end else if (aidx == sqs_pkg::IDX_STAT) begin
        next_st.rdata = {20'h0_0000, gpin_in, next_st.gp_on, next_st.rst_rel,
                         next_st.rb_en, next_st.ra_en, next_st.ph,
                         next_st.slot, next_st.mode};
      end else begin
        next_st.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  sqs_slot_timer #(
    .CNT_W (sqs_pkg::CNT_W),
    .C1    (DUR1_CYC),
    .C2    (DUR2_CYC),
    .C3    (DUR3_CYC)
  ) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (tmr_start),
    .code    (tmr_code),
    .done    (tmr_done)
  );

  sqs_gpin u_gpin (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .pol      (st.gp.pol),
    .is_out   (st.gout),
    .seq_on   (st.gp_on),
    .pin_in   (gpin_in),
    .pin_out  (gpin_out),
    .pin_oe_n (gpin_oe_n),
    .at_on    (at_on),
    .at_off   (at_off)
  );

  assign hreadyout   = 1'h1;
  assign hresp       = 1'h0;
  assign hrdata      = st.rdata;
  assign rail_a_en   = st.ra_en;
  assign rail_b_en   = st.rb_en;
  assign reset_out_n = st.rst_rel;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic act_cyc;
  logic dn_act;
  logic slot_rd;
  assign act_cyc = st.ph == sqs_pkg::PH_ACT &&
                   (st.mode == sqs_pkg::SQS_UP || st.mode == sqs_pkg::SQS_DOWN);
  assign dn_act  = act_cyc && st.mode == sqs_pkg::SQS_DOWN;
  assign slot_rd = st.dv && !st.dwr && st.didx >= sqs_pkg::IDX_RAIL_B &&
                   st.didx <= sqs_pkg::IDX_GPIN;

  nvm_load_a: assert property (!st.loaded |=>
    st.ra.up == $past(nvm_defaults.rail_a.up) &&
    st.ra.down == $past(nvm_defaults.rail_a.down) && st.gp == $past(nvm_defaults.gpin))
    else $error("defaults not loaded");
  rb_up_a: assert property (act_cyc && seq_up && st.rb.up == st.slot |=> rail_b_en)
    else $error("rail b not on in its slot");
  rb_dn_a: assert property (dn_act && st.rb.down == st.slot |=> !rail_b_en)
    else $error("rail b not off in its slot");
  ra_up_a: assert property (act_cyc && seq_up && st.ra.up == st.slot |=> rail_a_en)
    else $error("rail a not on in its slot");
  ra_dn_a: assert property (dn_act && st.ra.down == st.slot |=> !rail_a_en)
    else $error("rail a not off in its slot");
  rst_up_a: assert property (act_cyc && seq_up && st.rs.up == st.slot |=> reset_out_n)
    else $error("reset not released in its slot");
  rst_dn_a: assert property (dn_act && st.rs.down == st.slot |=> !reset_out_n)
    else $error("reset not asserted in its slot");
  pin_pol_a: assert property (!gpin_oe_n |->
    gpin_out == ($past(st.gp_on) ^ $past(st.gp.pol)))
    else $error("pin level ignores polarity");
  pin_up_a: assert property (act_cyc && seq_up && st.gout && st.gp.up == st.slot |->
    ##2 (gpin_out != st.gp.pol && !gpin_oe_n))
    else $error("pin not driven on");
  wait_up_a: assert property (seq_up && st.ph == sqs_pkg::PH_WAIT &&
    gpin_in == st.gp.pol |=> st.ph == sqs_pkg::PH_WAIT && $stable(st.slot))
    else $error("power-up left wait early");
  pin_dn_a: assert property (dn_act && st.gout && st.gp.down == st.slot |->
    ##2 (gpin_out == st.gp.pol && !gpin_oe_n))
    else $error("pin not driven off");
  wait_dn_a: assert property (st.mode == sqs_pkg::SQS_DOWN &&
    st.ph == sqs_pkg::PH_WAIT && gpin_in != st.gp.pol |=> st.ph == sqs_pkg::PH_WAIT)
    else $error("power-down left wait early");
  dur_zero_a: assert property (tmr_start |=>
    tmr_done == ($past(tmr_code) == sqs_pkg::DUR_ZERO))
    else $error("slot duration wrong");
  rsv_zero_a: assert property (slot_rd |-> hrdata[31:8] == 24'h00_0000 &&
    !hrdata[sqs_pkg::RSV_BIT] &&
    (st.didx == sqs_pkg::IDX_GPIN || !hrdata[sqs_pkg::POL_BIT]))
    else $error("reserved bits not zero");
  slot_asc_a: assert property (seq_up && st.ph == sqs_pkg::PH_TIME && tmr_done &&
    st.slot != sqs_pkg::LAST_SLOT |=> act_cyc && st.slot == $past(st.slot) + 3'h1)
    else $error("slots out of order");
  rail_pol_a: assert property (!st.rb.pol && !st.ra.pol && !st.rs.pol)
    else $error("rail or reset register keeps a polarity bit");
  in_undriven_a: assert property (!st.gout |=> gpin_oe_n)
    else $error("input pin driven");
  // Exit side of the pin waits; the hold side alone would pass a stuck wait
  wait_up_go_a: assert property (seq_up && st.ph == sqs_pkg::PH_WAIT &&
    gpin_in != st.gp.pol |=> st.ph == sqs_pkg::PH_TIME)
    else $error("power-up missed the on level");
  wait_dn_go_a: assert property (st.mode == sqs_pkg::SQS_DOWN &&
    st.ph == sqs_pkg::PH_WAIT && gpin_in == st.gp.pol |=> st.ph == sqs_pkg::PH_TIME)
    else $error("power-down missed the off level");
  req_up_a: assert property (st.mode == sqs_pkg::SQS_OFF && up_wr |=>
    seq_up && st.slot == 3'h0 && st.ph == sqs_pkg::PH_ACT)
    else $error("power-up not started at slot zero");
  up_last_a: assert property (seq_up && st.ph == sqs_pkg::PH_TIME && tmr_done &&
    st.slot == sqs_pkg::LAST_SLOT |=> st.mode == sqs_pkg::SQS_ON)
    else $error("power-up did not finish after the last slot");
  dn_last_a: assert property (st.mode == sqs_pkg::SQS_DOWN && st.ph == sqs_pkg::PH_TIME &&
    tmr_done && st.slot == sqs_pkg::LAST_SLOT |=> st.mode == sqs_pkg::SQS_OFF)
    else $error("power-down did not finish after the last slot");

  up_done_c: cover property (seq_up ##1 st.mode == sqs_pkg::SQS_ON);
  dn_done_c: cover property (st.mode == sqs_pkg::SQS_DOWN ##1 st.mode == sqs_pkg::SQS_OFF);
  pin_wait_c: cover property (st.ph == sqs_pkg::PH_WAIT [*3] ##1 st.ph == sqs_pkg::PH_TIME);
  dn_wait_c: cover property (st.mode == sqs_pkg::SQS_DOWN && st.ph == sqs_pkg::PH_WAIT ##1
    st.ph == sqs_pkg::PH_TIME);
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, (e), (g)); \
  end \
end

module tb_top;
  // Short slot times keep every sequence to a few dozen cycles
  localparam int D1 = 4;
  localparam int D2 = 6;
  localparam int D3 = 10;

  typedef struct {
    logic [7:0]  idx;
    logic [31:0] wdata;
    logic [31:0] exp;
  } sqs_row_t;

  logic              hclk;
  logic              hresetn;
  logic              hsel;
  logic [31:0]       haddr;
  logic [1:0]        htrans;
  logic              hwrite;
  logic [2:0]        hsize;
  logic [31:0]       hwdata;
  logic              hreadyout;
  logic              hresp;
  logic [31:0]       hrdata;
  sqs_pkg::sqs_nvm_t nvm;
  logic              rail_a_en;
  logic              rail_b_en;
  logic              reset_out_n;
  logic              gpin_in;
  logic              gpin_out;
  logic              gpin_oe_n;
  logic              pa;
  logic              pb;
  logic              pr;
  logic              pg;
  logic [31:0]       rd;
  int                fails;
  int                n_checks;
  int                cyc;
  int                t_a;
  int                t_b;
  int                t_r;
  int                t_g;
  int                i;
  int                d [4];
  sqs_row_t          rows [7];

  sqs_seq #(
    .DUR1_CYC (D1),
    .DUR2_CYC (D2),
    .DUR3_CYC (D3)
  ) sqs_seq_inst (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hreadyout),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .hrdata       (hrdata),
    .nvm_defaults (nvm),
    .rail_a_en    (rail_a_en),
    .rail_b_en    (rail_b_en),
    .reset_out_n  (reset_out_n),
    .gpin_in      (gpin_in),
    .gpin_out     (gpin_out),
    .gpin_oe_n    (gpin_oe_n)
  );

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Sampled at the falling edge so output updates have settled
  always @(negedge hclk) begin
    cyc++;
    if (rail_a_en !== pa) t_a = cyc;
    if (rail_b_en !== pb) t_b = cyc;
    if (reset_out_n !== pr) t_r = cyc;
    if (gpin_out !== pg) t_g = cyc;
    pa = rail_a_en;
    pb = rail_b_en;
    pr = reset_out_n;
    pg = gpin_out;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic time_out();
    fails++;
    $display("CHECK FAILED wait expected done seen timeout");
    tally_and_finish();
  endtask

  task automatic wait_rdy();
    int k;
    for (k = 0; k < 20; k++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (k == 20) time_out();
  endtask

  // Called just after a rising edge; the answer is never assumed to be immediate
  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {22'h0, idx, 2'h0};
    wait_rdy();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    ahb(1'b0, idx, 32'h0);
    `CHK("register read", exp, rd)
  endtask

  task automatic do_reset();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    `CHK("rail_a_en in reset", 1'b0, rail_a_en)
    `CHK("rail_b_en in reset", 1'b0, rail_b_en)
    `CHK("reset_out_n in reset", 1'b0, reset_out_n)
    `CHK("gpin_oe_n in reset", 1'b1, gpin_oe_n)
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  task automatic start(input logic [31:0] ctrl);
    t_a = -1;
    t_b = -1;
    t_r = -1;
    t_g = -1;
    ahb(1'b1, sqs_pkg::IDX_CTRL, ctrl);
  endtask

  task automatic wait_mode(input logic [1:0] m);
    int k;
    for (k = 0; k < 200; k++) begin
      ahb(1'b0, sqs_pkg::IDX_STAT, 32'h0);
      if (rd[1:0] === m) break;
    end
    if (k == 200) time_out();
  endtask

  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    gpin_in = 1'b0;
    nvm     = {7'h55, 7'h31, 7'h38, 7'h63, 16'h1b4e};
    rows = '{'{sqs_pkg::IDX_RAIL_B, 32'hffff_ffff, 32'h0000_0077},
             '{sqs_pkg::IDX_RAIL_B, 32'h0000_0000, 32'h0000_0000},
             '{sqs_pkg::IDX_RAIL_A, 32'h0000_00d5, 32'h0000_0055},
             '{sqs_pkg::IDX_RST, 32'h0000_00ab, 32'h0000_0023},
             '{sqs_pkg::IDX_GPIN, 32'h0000_00ff, 32'h0000_00f7},
             '{sqs_pkg::IDX_GPIN, 32'h0000_0008, 32'h0000_0000},
             '{8'h30, 32'hffff_ffff, 32'h0000_0000}};
    do_reset();
    // Rail B default carries a set polarity bit that must not show
    rdchk(sqs_pkg::IDX_RAIL_B, 32'h0000_0025);
    rdchk(sqs_pkg::IDX_RAIL_A, 32'h0000_0061);
    rdchk(sqs_pkg::IDX_RST, 32'h0000_0070);
    rdchk(sqs_pkg::IDX_GPIN, 32'h0000_00c3);
    rdchk(sqs_pkg::IDX_DUR, 32'h0000_1b4e);
    for (i = 0; i < 7; i++) begin
      ahb(1'b1, rows[i].idx, rows[i].wdata);
      ahb(1'b0, rows[i].idx, 32'h0);
      `CHK("slot register", rows[i].exp, rd)
      `CHK("hresp", 1'b0, hresp)
    end
    // Power-up and power-down order with the pin as an output
    ahb(1'b1, sqs_pkg::IDX_RAIL_A, 32'h0000_0016);
    ahb(1'b1, sqs_pkg::IDX_RAIL_B, 32'h0000_0030);
    ahb(1'b1, sqs_pkg::IDX_RST, 32'h0000_0054);
    ahb(1'b1, sqs_pkg::IDX_GPIN, 32'h0000_0022);
    ahb(1'b1, sqs_pkg::IDX_DUR, 32'h0000_5555);
    start(32'h0000_0005);
    wait_mode(sqs_pkg::SQS_ON);
    `CHK("up a before pin", 1'b1, t_a < t_g)
    `CHK("up pin before b", 1'b1, t_g < t_b)
    `CHK("up b before reset", 1'b1, t_b < t_r)
    `CHK("gpin_out on", 1'b1, gpin_out)
    `CHK("gpin_oe_n driven", 1'b0, gpin_oe_n)
    `CHK("reset_out_n released", 1'b1, reset_out_n)
    start(32'h0000_0006);
    wait_mode(sqs_pkg::SQS_OFF);
    `CHK("down b before pin", 1'b1, t_b < t_g)
    `CHK("down pin before reset", 1'b1, t_g < t_r)
    `CHK("down reset before a", 1'b1, t_r < t_a)
    `CHK("gpin_out off", 1'b0, gpin_out)
    `CHK("reset_out_n asserted", 1'b0, reset_out_n)
    // Pin as input with inverted polarity holds the sequence in its slot
    ahb(1'b1, sqs_pkg::IDX_GPIN, 32'h0000_00b2);
    gpin_in <= 1'b1;
    start(32'h0000_0001);
    repeat (40) @(posedge hclk);
    `CHK("pin not driven", 1'b1, gpin_oe_n)
    `CHK("reset held by wait", 1'b0, reset_out_n)
    rdchk(sqs_pkg::IDX_STAT, 32'h0000_09ad);
    gpin_in <= 1'b0;
    wait_mode(sqs_pkg::SQS_ON);
    `CHK("reset after wait", 1'b1, reset_out_n)
    start(32'h0000_0002);
    repeat (40) @(posedge hclk);
    `CHK("rail a held by wait", 1'b1, rail_a_en)
    ahb(1'b0, sqs_pkg::IDX_STAT, 32'h0);
    `CHK("down wait slot", 3'h2, rd[4:2])
    `CHK("down wait phase", 2'h1, rd[6:5])
    gpin_in <= 1'b1;
    wait_mode(sqs_pkg::SQS_OFF);
    `CHK("rail a after wait", 1'b0, rail_a_en)
    // Slot zero time for each code, measured between rail A and rail B
    ahb(1'b1, sqs_pkg::IDX_RAIL_A, 32'h0000_0006);
    ahb(1'b1, sqs_pkg::IDX_RAIL_B, 32'h0000_0010);
    ahb(1'b1, sqs_pkg::IDX_GPIN, 32'h0000_0077);
    for (i = 0; i < 4; i++) begin
      ahb(1'b1, sqs_pkg::IDX_DUR, i);
      start(32'h0000_0005);
      wait_mode(sqs_pkg::SQS_ON);
      d[i] = t_b - t_a;
      start(32'h0000_0006);
      wait_mode(sqs_pkg::SQS_OFF);
    end
    // Code zero ends one cycle after its start, so only differences are fixed
    `CHK("slot time code 1", D1 - 1, d[1] - d[0])
    `CHK("slot time code 2", D2 - D1, d[2] - d[1])
    `CHK("slot time code 3", D3 - D2, d[3] - d[2])
    // A second reset reloads from the new defaults, not from a constant
    nvm.gpin <= 7'h0e;
    do_reset();
    rdchk(sqs_pkg::IDX_GPIN, 32'h0000_0016);
    rdchk(sqs_pkg::IDX_RAIL_A, 32'h0000_0061);
    tally_and_finish();
  end
endmodule
